/* rtl/dmes_pkg.sv */
`default_nettype none
package dmes_pkg;
    // channel and queue geometry
    localparam int NCH_DMA = 32;
    localparam int NCH_QCK = 8;
    localparam int NCH = NCH_DMA + NCH_QCK;
    localparam int NQ = 2;
    localparam int QD = 4;
    localparam int DST_DEPTH = 4;
    localparam logic [2:0] DST_DEPTH_C = 3'h4;
    localparam logic [2:0] QD_C = 3'h4;
    // trigger source codes carried in each queue entry
    localparam logic [1:0] SRC_EVT = 2'h0;
    localparam logic [1:0] SRC_CHAIN = 2'h1;
    localparam logic [1:0] SRC_MAN = 2'h2;
    localparam logic [1:0] SRC_QCK = 2'h3;
    // register byte offsets
    localparam logic [11:0] OFS_EVT = 12'h000;
    localparam logic [11:0] OFS_CHAIN = 12'h004;
    localparam logic [11:0] OFS_MAN = 12'h008;
    localparam logic [11:0] OFS_QEVT = 12'h00c;
    localparam logic [11:0] OFS_SEC = 12'h010;
    localparam logic [11:0] OFS_QSEC = 12'h014;
    localparam logic [11:0] OFS_PEND = 12'h018;
    localparam logic [11:0] OFS_QSEL = 12'h01c;
    localparam logic [11:0] OFS_QQSEL = 12'h020;
    localparam logic [11:0] OFS_XFER_CTRL_STATUS = 12'h024;
    localparam logic [11:0] OFS_PRIO = 12'h028;
    localparam logic [3:0] OFS_PSET_PAGE = 4'h1;
    // field positions
    localparam int STAT_STRIDE = 8;
    localparam int STAT_CNT_POS = 2;
    localparam int STAT_SRC_POS = 5;
    localparam int STAT_PROG_POS = 6;
    localparam int PRIO_STRIDE = 4;
    localparam int PSET_NULL_POS = 6;
    localparam int PSET_EARLY_POS = 5;
    // reset values
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    typedef struct packed {
        logic [5:0] ch;
        logic [1:0] src;
    } dmes_ent_s;

    typedef struct packed {
        logic early;
        logic [4:0] code;
    } dmes_pay_s;

    typedef struct packed {
        logic nul;
        logic early;
        logic [4:0] code;
    } dmes_pset_s;

    // command to a source or destination endpoint
    typedef struct packed {
        logic valid;
        logic [1:0] tag;
        logic [2:0] prio;
    } dmes_cmd_s;
endpackage
`default_nettype wire

/* rtl/dmes_top.sv */
// Function
// (RULE_01) circular destination set, depth four, head index
// (RULE_02) status shows destination head index
// (RULE_03) status shows occupied count, zero means empty
// (RULE_04) pending entries run from head with wrap
// (RULE_05) latch each trigger into its channel bit
// (RULE_06) set secondary flag once event is queued
// (RULE_07) empty queue and idle controller: bypass queue
// (RULE_08) check parameter set for null before submission
// (RULE_09) non-null clears latch and flag; null keeps flag
// (RULE_10) early completion sets pending bit at submission
// (RULE_11) normal completion sets pending bit on return
// (RULE_12) program set moves only when both sets free
// (RULE_13) reads fill data, writes start once buffered
// (RULE_14) last write done reports completion code back
// (RULE_15) lowest channel number queued first
// (RULE_16) ordering only among same-cycle events
// (RULE_17) dma event beats quick event
// (RULE_18) peripheral, then chain, then manual trigger
// (RULE_19) queue select picks queue and controller
// (RULE_20) lower-numbered queue dequeues first
// (RULE_21) busy controller never blocks another queue
// (RULE_22) commands carry priority 0..7, reset 0
// (RULE_23) writes issued in request order
// (RULE_24) count up on entry, down on finish, head wraps
`default_nettype none
module dmes_top
    import dmes_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [dmes_pkg::NCH_DMA-1:0] EVT_IN,
    input wire logic [dmes_pkg::NCH_DMA-1:0] CHAIN_IN,
    input wire logic [dmes_pkg::NCH_QCK-1:0] QEVT_IN,
    output dmes_pkg::dmes_cmd_s [dmes_pkg::NQ-1:0] TC_RD_CMD_OUT,
    input wire logic [dmes_pkg::NQ-1:0] TC_RD_READY_IN,
    input wire logic [dmes_pkg::NQ-1:0] TC_RD_DONE_IN,
    input wire logic [dmes_pkg::NQ-1:0][1:0] TC_RD_DONE_TAG_IN,
    output dmes_pkg::dmes_cmd_s [dmes_pkg::NQ-1:0] TC_WR_CMD_OUT,
    input wire logic [dmes_pkg::NQ-1:0] TC_WR_READY_IN,
    input wire logic [dmes_pkg::NQ-1:0] TC_WR_DONE_IN
);
    import dmes_pkg::*;

    typedef struct packed {
        logic [NCH_DMA-1:0] evt_s1;
        logic [NCH_DMA-1:0] evt_s2;
        logic [NCH_DMA-1:0] evt_d;
        logic [NCH_DMA-1:0] event_latch_reg;
        logic [NCH_DMA-1:0] chain_event_latch;
        logic [NCH_DMA-1:0] manual_event_set;
        logic [NCH_QCK-1:0] quick_event_latch;
        logic [NCH_DMA-1:0] secondary_event_flag;
        logic [NCH_QCK-1:0] quick_secondary_flag;
        logic [31:0] completion_pending_reg;
        logic [NCH_DMA-1:0] channel_queue_select;
        logic [NCH_QCK-1:0] quick_queue_select;
        logic [NQ-1:0][2:0] prio;
        dmes_pset_s [NCH-1:0] memory_a;
        dmes_ent_s [NQ-1:0][QD-1:0] q;
        logic [NQ-1:0][1:0] qhead;
        logic [NQ-1:0][2:0] qcnt;
        logic sub_v;
        logic sub_q;
        dmes_ent_s sub_e;
        logic [NQ-1:0] prog_v;
        dmes_pay_s [NQ-1:0] prog;
        logic [NQ-1:0] src_v;
        logic [NQ-1:0][1:0] src_tag;
        dmes_pay_s [NQ-1:0][DST_DEPTH-1:0] dst;
        logic [NQ-1:0][DST_DEPTH-1:0] data_ok;
        logic [NQ-1:0][1:0] dst_fifo_head_index;
        logic [NQ-1:0][2:0] dst_active_count;
        logic [NQ-1:0] wr_busy;
        logic apb_ack;
        logic apb_err;
        logic [31:0] apb_rdata;
    } dmes_state_s;

    dmes_state_s s;
    dmes_state_s next_s;

    logic wr_fire;
    logic pick_v;
    logic pick_quick;
    logic [5:0] pick_ch;
    logic [1:0] pick_src;
    logic pick_q;
    logic [NCH_DMA-1:0] dma_pend;
    logic [NCH_QCK-1:0] qck_pend;
    logic deq_v;
    logic deq_q;
    logic [31:0] xfer_ctrl_status;
    logic [31:0] rd_word;
    logic rd_err;
    dmes_pset_s sub_ps;

    // wrap an index into a circular set of the given depth
    function automatic logic [1:0] wrap_add(input logic [1:0] a, input logic [2:0] b,
                                            input logic [2:0] depth);
        logic [3:0] sum;
        sum = {2'h0, a} + {1'h0, b};
        if (sum >= {1'h0, depth}) begin
            sum = sum - {1'h0, depth};
        end
        return sum[1:0];
    endfunction

    // status word: per controller head, count, source busy, program busy
    always_comb begin
        xfer_ctrl_status = ZERO_RST;
        for (int n = 0; n < NQ; n++) begin
            xfer_ctrl_status[n*STAT_STRIDE +: 2] = s.dst_fifo_head_index[n]; // [RULE_02]
            xfer_ctrl_status[n*STAT_STRIDE+STAT_CNT_POS +: 3] = s.dst_active_count[n]; // [RULE_03]
            xfer_ctrl_status[n*STAT_STRIDE+STAT_SRC_POS] = s.src_v[n];
            xfer_ctrl_status[n*STAT_STRIDE+STAT_PROG_POS] = s.prog_v[n];
        end
    end

    // read decode; unmapped addresses answer zero with an error
    always_comb begin
        rd_word = ZERO_RST;
        rd_err = 1'b0;
        case (PADDR_IN)
            OFS_EVT: rd_word = s.event_latch_reg;
            OFS_CHAIN: rd_word = s.chain_event_latch;
            OFS_MAN: rd_word = s.manual_event_set;
            OFS_QEVT: rd_word = {24'h0, s.quick_event_latch};
            OFS_SEC: rd_word = s.secondary_event_flag;
            OFS_QSEC: rd_word = {24'h0, s.quick_secondary_flag};
            OFS_PEND: rd_word = s.completion_pending_reg;
            OFS_QSEL: rd_word = s.channel_queue_select;
            OFS_QQSEL: rd_word = {24'h0, s.quick_queue_select};
            OFS_XFER_CTRL_STATUS: rd_word = xfer_ctrl_status;
            OFS_PRIO: begin
                for (int n = 0; n < NQ; n++) begin
                    rd_word[n*PRIO_STRIDE +: 3] = s.prio[n];
                end
            end
            default: begin
                if (PADDR_IN[11:8] == OFS_PSET_PAGE && PADDR_IN[7:2] < 6'(NCH)) begin
                    rd_word = {25'h0, s.memory_a[PADDR_IN[7:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // event selection: lowest channel of those pending this cycle, dma before quick
    always_comb begin
        dma_pend = (s.event_latch_reg | s.chain_event_latch | s.manual_event_set)
                   & ~s.secondary_event_flag;
        qck_pend = s.quick_event_latch & ~s.quick_secondary_flag;
        pick_v = 1'b0;
        pick_quick = 1'b0;
        pick_ch = 6'h00;
        pick_src = SRC_EVT;
        pick_q = 1'b0;
        for (int i = NCH_QCK - 1; i >= 0; i--) begin
            if (qck_pend[i]) begin
                pick_v = 1'b1;
                pick_quick = 1'b1;
                pick_ch = 6'(NCH_DMA + i);
                pick_src = SRC_QCK;
                pick_q = s.quick_queue_select[i]; // [RULE_19]
            end
        end
        for (int i = NCH_DMA - 1; i >= 0; i--) begin
            if (dma_pend[i]) begin // [RULE_15] [RULE_17]
                pick_v = 1'b1;
                pick_quick = 1'b0;
                pick_ch = 6'(i);
                pick_q = s.channel_queue_select[i]; // [RULE_19]
                if (s.event_latch_reg[i]) begin // [RULE_18]
                    pick_src = SRC_EVT;
                end else if (s.chain_event_latch[i]) begin
                    pick_src = SRC_CHAIN;
                end else begin
                    pick_src = SRC_MAN;
                end
            end
        end
        // dequeue: lowest queue whose controller is free; a busy one is skipped
        deq_v = 1'b0;
        deq_q = 1'b0;
        for (int n = NQ - 1; n >= 0; n--) begin
            if (s.qcnt[n] != 3'h0 && !s.prog_v[n] && !s.sub_v) begin // [RULE_20] [RULE_21]
                deq_v = 1'b1;
                deq_q = 1'(n);
            end
        end
        sub_ps = s.memory_a[s.sub_e.ch];
    end

    assign wr_fire = PSEL_IN && PENABLE_IN && PWRITE_IN && s.apb_ack;

    // next state
    always_comb begin
        next_s = s;
        next_s.evt_s1 = EVT_IN;
        next_s.evt_s2 = s.evt_s1;
        next_s.evt_d = s.evt_s2;
        // bus: one wait state, data captured into a flop on the first access cycle
        next_s.apb_ack = PSEL_IN && PENABLE_IN && !s.apb_ack;
        if (PSEL_IN && PENABLE_IN && !s.apb_ack) begin
            next_s.apb_rdata = PWRITE_IN ? ZERO_RST : rd_word;
            next_s.apb_err = rd_err;
        end
        // software clears go first so that hardware sets in the same cycle win
        if (wr_fire) begin
            case (PADDR_IN)
                OFS_MAN: next_s.manual_event_set = s.manual_event_set | PWDATA_IN; // [RULE_05]
                OFS_SEC: next_s.secondary_event_flag = s.secondary_event_flag & ~PWDATA_IN;
                OFS_QSEC: begin
                    next_s.quick_secondary_flag = s.quick_secondary_flag & ~PWDATA_IN[7:0];
                end
                OFS_PEND: begin
                    next_s.completion_pending_reg = s.completion_pending_reg & ~PWDATA_IN;
                end
                OFS_QSEL: next_s.channel_queue_select = PWDATA_IN;
                OFS_QQSEL: next_s.quick_queue_select = PWDATA_IN[7:0];
                OFS_PRIO: begin
                    for (int n = 0; n < NQ; n++) begin
                        next_s.prio[n] = PWDATA_IN[n*PRIO_STRIDE +: 3]; // [RULE_22]
                    end
                end
                default: begin
                    if (PADDR_IN[11:8] == OFS_PSET_PAGE && PADDR_IN[7:2] < 6'(NCH)) begin
                        next_s.memory_a[PADDR_IN[7:2]] = PWDATA_IN[6:0];
                    end
                end
            endcase
        end
        // trigger latching: rising edge of a synchronised pin, or a pulse from logic
        next_s.event_latch_reg = next_s.event_latch_reg | (s.evt_s2 & ~s.evt_d); // [RULE_05]
        next_s.chain_event_latch = s.chain_event_latch | CHAIN_IN; // [RULE_05]
        next_s.quick_event_latch = s.quick_event_latch | QEVT_IN; // [RULE_05]
        // submission stage: null sets leave the secondary flag standing
        if (s.sub_v) begin
            next_s.sub_v = 1'b0;
            if (!sub_ps.nul) begin // [RULE_08]
                case (s.sub_e.src) // [RULE_09]
                    SRC_EVT: next_s.event_latch_reg[s.sub_e.ch[4:0]] = 1'b0;
                    SRC_CHAIN: next_s.chain_event_latch[s.sub_e.ch[4:0]] = 1'b0;
                    SRC_MAN: next_s.manual_event_set[s.sub_e.ch[4:0]] = 1'b0;
                    default: next_s.quick_event_latch[s.sub_e.ch[2:0]] = 1'b0;
                endcase
                if (s.sub_e.src == SRC_QCK) begin
                    next_s.quick_secondary_flag[s.sub_e.ch[2:0]] = 1'b0; // [RULE_09]
                end else begin
                    next_s.secondary_event_flag[s.sub_e.ch[4:0]] = 1'b0; // [RULE_09]
                end
                next_s.prog_v[s.sub_q] = 1'b1;
                next_s.prog[s.sub_q] = {sub_ps.early, sub_ps.code};
                if (sub_ps.early) begin
                    next_s.completion_pending_reg[sub_ps.code] = 1'b1; // [RULE_10]
                end
            end
        end
        // dequeue into the submission stage
        if (deq_v) begin
            next_s.sub_v = 1'b1;
            next_s.sub_q = deq_q;
            next_s.sub_e = s.q[deq_q][s.qhead[deq_q]];
            next_s.qhead[deq_q] = wrap_add(s.qhead[deq_q], 3'h1, QD_C);
            next_s.qcnt[deq_q] = s.qcnt[deq_q] - 3'h1;
        end
        // one new event per cycle; queued events are never reordered
        if (pick_v) begin
            if (!deq_v && !s.sub_v && s.qcnt[pick_q] == 3'h0 && !s.prog_v[pick_q]) begin
                next_s.sub_v = 1'b1; // [RULE_07]
                next_s.sub_q = pick_q;
                next_s.sub_e = {pick_ch, pick_src};
            end else if (s.qcnt[pick_q] < QD_C) begin
                next_s.q[pick_q][wrap_add(s.qhead[pick_q], s.qcnt[pick_q], QD_C)] =
                    {pick_ch, pick_src}; // [RULE_16]
                next_s.qcnt[pick_q] = next_s.qcnt[pick_q] + 3'h1;
            end
            if (next_s.sub_v && next_s.sub_e == {pick_ch, pick_src} ||
                next_s.qcnt[pick_q] != s.qcnt[pick_q] - 3'(deq_v && deq_q == pick_q)) begin
                if (pick_quick) begin
                    next_s.quick_secondary_flag[pick_ch[2:0]] = 1'b1; // [RULE_06]
                end else begin
                    next_s.secondary_event_flag[pick_ch[4:0]] = 1'b1; // [RULE_06]
                end
            end
        end
        // transfer controllers
        for (int n = 0; n < NQ; n++) begin
            if (s.src_v[n] && TC_RD_READY_IN[n]) begin
                next_s.src_v[n] = 1'b0; // [RULE_13]
            end
            if (TC_RD_DONE_IN[n]) begin
                next_s.data_ok[n][TC_RD_DONE_TAG_IN[n]] = 1'b1; // [RULE_13]
            end
            if (s.prog_v[n] && !s.src_v[n] && s.dst_active_count[n] < DST_DEPTH_C) begin
                next_s.prog_v[n] = 1'b0; // [RULE_12]
                next_s.src_v[n] = 1'b1;
                next_s.src_tag[n] = wrap_add(s.dst_fifo_head_index[n], s.dst_active_count[n],
                                             DST_DEPTH_C);
                next_s.dst[n][next_s.src_tag[n]] = s.prog[n];
                next_s.data_ok[n][next_s.src_tag[n]] = 1'b0;
                next_s.dst_active_count[n] = s.dst_active_count[n] + 3'h1; // [RULE_24]
            end
            if (TC_WR_CMD_OUT[n].valid && TC_WR_READY_IN[n]) begin
                next_s.wr_busy[n] = 1'b1;
            end
            if (s.wr_busy[n] && TC_WR_DONE_IN[n]) begin
                next_s.wr_busy[n] = 1'b0;
                if (!s.dst[n][s.dst_fifo_head_index[n]].early) begin
                    next_s.completion_pending_reg[s.dst[n][s.dst_fifo_head_index[n]].code] =
                        1'b1; // [RULE_11] [RULE_14]
                end
                next_s.dst_fifo_head_index[n] = wrap_add(s.dst_fifo_head_index[n], 3'h1,
                                                         DST_DEPTH_C); // [RULE_24]
                next_s.dst_active_count[n] = next_s.dst_active_count[n] - 3'h1; // [RULE_24]
            end
        end
    end

    // state register; the parameter memory clears too, but software must still write it first
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            s <= '0;
            for (int n = 0; n < NQ; n++) begin
                s.prio[n] <= PRIO_RST; // [RULE_22]
            end
        end else begin
            s <= next_s;
        end
    end

    // outputs: the write valid is combinational; the read valid, tags and priority come from flops
    always_comb begin
        for (int n = 0; n < NQ; n++) begin
            TC_RD_CMD_OUT[n] = {s.src_v[n], s.src_tag[n], s.prio[n]}; // [RULE_22]
            TC_WR_CMD_OUT[n] = {s.dst_active_count[n] != 3'h0 && !s.wr_busy[n] &&
                                s.data_ok[n][s.dst_fifo_head_index[n]],
                                s.dst_fifo_head_index[n], s.prio[n]}; // [RULE_04] [RULE_23]
        end
    end
    assign PREADY_OUT = PSEL_IN && PENABLE_IN && s.apb_ack;
    assign PRDATA_OUT = s.apb_rdata;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && s.apb_ack && s.apb_err;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    sequence early_submit;
        s.sub_v && !sub_ps.nul && sub_ps.early;
    endsequence

    early_pending_set_a: assert property (early_submit |=> // [RULE_10]
        s.completion_pending_reg[$past(sub_ps.code)])
        else $error("early completion bit not set after submission");

    null_keeps_flag_a: assert property ( // [RULE_09]
        (s.sub_v && sub_ps.nul && s.sub_e.src != SRC_QCK && !wr_fire) |=>
        s.secondary_event_flag[$past(s.sub_e.ch[4:0])])
        else $error("secondary flag dropped for a null set");

    queued_flag_set_a: assert property ( // [RULE_06]
        (pick_v && !pick_quick && !s.secondary_event_flag[pick_ch[4:0]] && !wr_fire &&
         s.qcnt[pick_q] < QD_C) |=> s.secondary_event_flag[$past(pick_ch[4:0])])
        else $error("secondary flag not set for queued event");

    dma_over_quick_a: assert property ( // [RULE_17] [RULE_15]
        (pick_v && pick_quick) |-> (dma_pend == '0))
        else $error("quick event picked while a dma event waits");

    for (genvar g = 0; g < NQ; g++) begin : g_chk
        count_bound_a: assert property ( // [RULE_01]
            s.dst_active_count[g] <= DST_DEPTH_C)
            else $error("destination count above depth");

        empty_no_write_a: assert property ( // [RULE_03]
            (s.dst_active_count[g] == 3'h0) |-> !TC_WR_CMD_OUT[g].valid)
            else $error("write issued with empty destination set");

        write_order_a: assert property ( // [RULE_23] [RULE_04]
            TC_WR_CMD_OUT[g].valid |-> (TC_WR_CMD_OUT[g].tag == s.dst_fifo_head_index[g]))
            else $error("write not taken from head entry");

        head_advance_a: assert property ( // [RULE_24]
            (s.wr_busy[g] && TC_WR_DONE_IN[g]) |=> (s.dst_fifo_head_index[g] ==
            wrap_add($past(s.dst_fifo_head_index[g]), 3'h1, DST_DEPTH_C)))
            else $error("head index did not advance on completion");

        fill_needs_room_a: assert property ( // [RULE_12]
            (s.dst_active_count[g] > $past(s.dst_active_count[g])) |->
            ($past(s.dst_active_count[g]) < DST_DEPTH_C))
            else $error("destination set filled without room");
    end
endmodule // dmes_top
`default_nettype wire

/* sim/dmes_ep_model.sv */
`default_nettype none
module dmes_ep_model
    import dmes_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire dmes_pkg::dmes_cmd_s rd_cmd_in,
    output logic rd_ready_out,
    output logic rd_done_out,
    output logic [1:0] rd_tag_out,
    input wire dmes_pkg::dmes_cmd_s wr_cmd_in,
    output logic wr_ready_out,
    output logic wr_done_out
);
    // a stalled endpoint takes neither reads nor writes
    assign rd_ready_out = ~stall_in;
    assign wr_ready_out = ~stall_in;
    // answers come one cycle after a command is taken
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_done_out <= 1'b0;
            rd_tag_out <= 2'h0;
            wr_done_out <= 1'b0;
        end else begin
            rd_done_out <= rd_cmd_in.valid & ~stall_in;
            // idle tag toggles so a stale value never looks valid
            rd_tag_out <= rd_cmd_in.valid ? rd_cmd_in.tag : ~rd_tag_out;
            wr_done_out <= wr_cmd_in.valid & ~stall_in;
        end
    end
endmodule // dmes_ep_model
`default_nettype wire

/* sim/test_dma_event_submit_priority.sv */
`default_nettype none
module test_dma_event_submit_priority;
    import dmes_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic [31:0] evt = 32'h0, chain = 32'h0;
    logic [7:0] qevt = 8'h0;
    logic [1:0] stall = 2'h0, rd_ready, rd_done, wr_ready, wr_done;
    logic [1:0][1:0] rd_tag;
    dmes_cmd_s [1:0] rd_cmd, wr_cmd;
    int n_checks = 0, n_mismatch = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    dmes_top uut (.CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EVT_IN(evt), .CHAIN_IN(chain),
        .QEVT_IN(qevt), .TC_RD_CMD_OUT(rd_cmd), .TC_RD_READY_IN(rd_ready),
        .TC_RD_DONE_IN(rd_done), .TC_RD_DONE_TAG_IN(rd_tag), .TC_WR_CMD_OUT(wr_cmd),
        .TC_WR_READY_IN(wr_ready), .TC_WR_DONE_IN(wr_done));
    for (genvar i = 0; i < 2; i++) begin : g_ep
        dmes_ep_model u_ep (.clk_in(clk), .rst_in(rst), .stall_in(stall[i]),
            .rd_cmd_in(rd_cmd[i]), .rd_ready_out(rd_ready[i]), .rd_done_out(rd_done[i]),
            .rd_tag_out(rd_tag[i]), .wr_cmd_in(wr_cmd[i]), .wr_ready_out(wr_ready[i]),
            .wr_done_out(wr_done[i]));
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; pready is taken at a rising edge, then the bus idles one cycle
    // so that a following call never raises psel in the edge that lowered it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_mismatch++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // re-read a register until the masked field matches, bounded
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        int i;
        for (i = 0; i < 40; i++) begin
            apb(1'b0, a, 32'h0, r, e);
            if ((r & m) === x) break;
        end
        chk(r & m, x);
        if (i == 40) end_of_test();
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h200, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        poll(OFS_XFER_CTRL_STATUS, 32'hffff, 32'h0);
        poll(OFS_PRIO, 32'hff, 32'h0);
        $display("test reset done");
    endtask
    // early completion while the endpoint stalls, then normal completion
    task automatic t_compl();
        stall <= 2'h1;
        wr(12'h10c, 32'h27);
        wr(12'h110, 32'h09);
        wr(OFS_MAN, 32'h8);
        poll(OFS_PEND, 32'h80, 32'h80);
        poll(OFS_MAN, 32'h8, 32'h0);
        poll(OFS_XFER_CTRL_STATUS, 32'h1f, 32'h04);
        evt <= 32'h10;
        poll(OFS_XFER_CTRL_STATUS, 32'h5c, 32'h44);
        poll(OFS_PEND, 32'h200, 32'h0);
        stall <= 2'h0;
        evt <= 32'h0;
        poll(OFS_PEND, 32'h280, 32'h280);
        poll(OFS_XFER_CTRL_STATUS, 32'h1f, 32'h02);
        wr(OFS_PEND, 32'h280);
        poll(OFS_PEND, 32'h280, 32'h0);
        $display("test completion done");
    endtask
    task automatic t_null();
        wr(12'h114, 32'h40);
        wr(OFS_MAN, 32'h20);
        poll(OFS_SEC, 32'h20, 32'h20);
        poll(OFS_MAN, 32'h20, 32'h20);
        // a null set keeps its latch, so the set is made real before the flag is freed
        wr(12'h114, 32'h00);
        wr(OFS_SEC, 32'h20);
        poll(OFS_SEC, 32'h20, 32'h0);
        poll(OFS_MAN, 32'h20, 32'h0);
        poll(OFS_PEND, 32'h1, 32'h1);
        $display("test null done");
    endtask
    // quick channel 0, early completion with code 2, routed to queue 0
    task automatic t_quick();
        wr(12'h180, 32'h22);
        qevt <= 8'h01;
        @(posedge clk) qevt <= 8'h00;
        poll(OFS_PEND, 32'h4, 32'h4);
        poll(OFS_QEVT, 32'h1, 32'h0);
        poll(OFS_QSEC, 32'h1, 32'h0);
        $display("test quick done");
    endtask
    // channel 6 routed to queue 1, whose commands carry priority 5
    task automatic t_prio();
        int i;
        stall <= 2'h2;
        wr(OFS_PRIO, 32'h50);
        wr(OFS_QSEL, 32'h40);
        wr(12'h118, 32'h21);
        chain <= 32'h40;
        @(posedge clk) chain <= 32'h0;
        for (i = 0; i < 40 && rd_cmd[1].valid !== 1'b1; i++) @(posedge clk);
        chk({31'h0, rd_cmd[1].valid}, 32'h1);
        chk({29'h0, rd_cmd[1].prio}, 32'h5);
        poll(OFS_XFER_CTRL_STATUS, 32'h1c1c, 32'h0400);
        stall <= 2'h0;
        poll(OFS_XFER_CTRL_STATUS, 32'h1f00, 32'h0100);
        $display("test priority done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_compl();
        t_null();
        t_quick();
        t_prio();
        end_of_test();
    end
endmodule // test_dma_event_submit_priority
`default_nettype wire
